// ===== dv/gpio_alternate_function_mux_test.sv
// self-checking bench for the pin multiplexer: table of selections, then awkward cases and reset last
// assumes the constants header on the include path; inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`include "gpio_mux_consts.svh"

module gpio_alternate_function_mux_test;
    typedef struct packed {
        logic [1:0]  src;                          // 0 software, 1 management bus, 2 loader
        logic [15:0] sel, dir, data;
        logic [3:0]  fn;                           // {event, port6, port4, port2} requests
        logic [15:0] oe, out;                      // expected enables and driven values
    } row_t;
    row_t rows [10] = '{
        '{2'h0, 16'h0000, 16'hFFFF, 16'hA5A5, 4'hF, 16'hFFFF, 16'hA5A5},
        '{2'h1, 16'h0000, 16'h00FF, 16'h0F1F, 4'h0, 16'h00FF, 16'h001F},
        '{2'h2, 16'hFFFF, 16'hFFFF, 16'h0000, 4'h0, 16'hFFEB, 16'h0883},
        '{2'h0, 16'h0897, 16'h0000, 16'hFFFF, 4'hF, 16'h0883, 16'h0000},
        '{2'h1, 16'h0001, 16'h0000, 16'h0000, 4'h1, 16'h0001, 16'h0000},
        '{2'h2, 16'h0002, 16'h0000, 16'hFFFF, 4'h2, 16'h0002, 16'h0000},
        '{2'h0, 16'h0080, 16'h0000, 16'h0000, 4'h0, 16'h0080, 16'h0080},
        '{2'h1, 16'h0080, 16'h0000, 16'hFFFF, 4'h8, 16'h0080, 16'h0000},
        '{2'h2, 16'h0800, 16'h0000, 16'h0000, 4'h4, 16'h0800, 16'h0000},
        '{2'h0, 16'h0014, 16'hFFFF, 16'hFFFF, 4'h0, 16'hFFEB, 16'hFFEB}};

    logic clk = 1'b0, rst = 1'b1, en = 1'b1, sw_wr = 1'b0, smb_wr = 1'b0, ee_wr = 1'b0, stuck = 1'b0;
    logic [15:0] dir = 16'h0, data = 16'h0, sw_d = 16'h0, smb_d = 16'h0, ee_d = 16'h0, low = 16'h0;
    logic [15:0] pad_val, pad_oe, pad_lvl, rd, sel;
    logic [3:0]  fn = 4'h0, dly = 4'h0;
    logic [1:0]  req, ack, irq = 2'h0;
    logic [7:0]  r0, r1;
    int          n_mismatch = 0, comparisons = 0;

    always #5 clk = ~clk;                          // 100 MHz

    gpio_alternate_function_mux i_dut (.clk_in(clk), .sys_rst_in(rst), .clk_en_in(en), .gpio_in_in(pad_lvl),
        .gpio_out_out(pad_val), .gpio_oe_out(pad_oe), .gpio_read_out(rd), .sw_dir_in(dir), .sw_data_in(data),
        .sw_alt_wr_in(sw_wr), .sw_alt_data_in(sw_d), .smb_alt_wr_in(smb_wr), .smb_alt_data_in(smb_d),
        .eeprom_alt_wr_in(ee_wr), .eeprom_alt_data_in(ee_d), .alt_sel_out(sel), .port2_reset_in(fn[0]),
        .port4_reset_in(fn[1]), .port6_reset_in(fn[2]), .system_event_in(fn[3]),
        .expander_read_req_out(req), .expander_read_ack_in(ack));
    hotplug_partner_model i_partner (.clk_in(clk), .pad_val_in(pad_val), .pad_oe_in(pad_oe), .board_low_in(low),
        .irq_set_in(irq), .irq_stuck_in(stuck), .ack_delay_in(dly), .read_req_in(req), .read_ack_out(ack),
        .pad_level_out(pad_lvl), .reads0_out(r0), .reads1_out(r1));

    // one comparison, four-state exact
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // move to just after the n-th next rising edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    // one-cycle selection write through the chosen source
    task automatic write_sel(input logic [1:0] src, input logic [15:0] val);
        case (src)
            2'h0: begin sw_wr = 1'b1; sw_d = val; end
            2'h1: begin smb_wr = 1'b1; smb_d = val; end
            default: begin ee_wr = 1'b1; ee_d = val; end
        endcase
        step(1);
        {sw_wr, smb_wr, ee_wr} = 3'h0;
    endtask : write_sel

    // expander change on channel c, bounded waits for the request to rise and to clear
    task automatic irq_round(input int c, input logic [3:0] d);
        int k;
        k = 0;
        dly = d;
        irq[c] = 1'b1;
        step(1);
        irq[c] = 1'b0;
        while (req[c] !== 1'b1 && k < 12) begin step(1); k++; end
        check({15'h0, req[c]}, 16'h0001);
        k = 0;
        while (req[c] !== 1'b0 && k < 30) begin step(1); k++; end
        check({15'h0, req[c]}, 16'h0000);
    endtask : irq_round

    // verdict and end of run
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    // watchdog: the tests need about 200 cycles
    initial begin
        #50000;
        n_mismatch++;
        complete_run();
    end

    // main sequence
    initial begin
        step(8);
        rst = 1'b0;
        foreach (rows[i]) begin
            write_sel(rows[i].src, rows[i].sel);
            check(sel, rows[i].sel & `ALT_MASK);
            {dir, data, fn} = {rows[i].dir, rows[i].data, rows[i].fn};
            step(6);
            check(pad_oe, rows[i].oe);
            check(pad_val & pad_oe, rows[i].out);
            check(rd, rows[i].out | ~rows[i].oe);
        end
        $display("test table done");
        sw_d = 16'h0001; smb_d = 16'h0002; ee_d = 16'h0080; {sw_wr, smb_wr, ee_wr} = 3'h7;
        step(1);
        sw_wr = 1'b0;
        check(sel, 16'h0001);
        step(1);
        {smb_wr, ee_wr} = 2'h0;
        check(sel, 16'h0002);
        $display("test priority done");
        write_sel(2'h0, 16'h0000);
        {dir, data, low} = {16'h00FF, 16'h1234, 16'h0108};
        step(6);
        check(rd, 16'hFEF7 & (16'hFF00 | 16'h0034));
        en = 1'b0;
        data = 16'h4335;                           // pins 2 and 4 stay high: no false interrupt on selection
        step(3);
        check(pad_val & pad_oe, 16'h0034);
        en = 1'b1;
        step(3);
        check(pad_val & pad_oe, 16'h0035);
        $display("test plain pins done");
        write_sel(2'h1, 16'h0014);
        low = 16'h0000;
        step(6);
        irq_round(0, 4'h0);
        check({r1, r0}, 16'h0001);
        irq_round(1, 4'h9);
        check({r1, r0}, 16'h0101);
        stuck = 1'b1;
        irq_round(0, 4'h2);
        step(40);
        check({r1, r0}, 16'h0102);
        write_sel(2'h2, 16'h0000);
        dir = 16'h0000;
        step(6);
        check({14'h0, req}, 16'h0000);
        check(rd & 16'h0014, 16'h0010);
        stuck = 1'b0;
        $display("test expander done");
        write_sel(2'h0, 16'hFFFF);
        {dir, fn} = {16'hFFFF, 4'hF};
        rst = 1'b1;
        step(2);
        check(sel | pad_oe | pad_val, 16'h0000);
        check({14'h0, req}, 16'h0000);
        step(4);
        check(rd, 16'hFFFF);
        rst = 1'b0;
        $display("test reset done");
        complete_run();
    end
endmodule : gpio_alternate_function_mux_test

// ===== dv/hotplug_partner_model.sv
// board model: expander interrupt lines, pull-ups, board parts and the hot-plug read master
// assumes the mux drives pads through gpio_out_out/gpio_oe_out; released lines float high
`timescale 1ns/1ps
`include "gpio_mux_consts.svh"

module hotplug_partner_model (
    input  wire logic               clk_in,
    input  wire logic [`GPIO_W-1:0] pad_val_in,    // mux driver values
    input  wire logic [`GPIO_W-1:0] pad_oe_in,     // mux enables, high drives
    input  wire logic [`GPIO_W-1:0] board_low_in,  // board parts pulling plain pins low
    input  wire logic [1:0]         irq_set_in,    // expander sees a hot-plug change
    input  wire logic               irq_stuck_in,  // faulty expander keeps its line low after a read
    input  wire logic [3:0]         ack_delay_in,  // read latency, prompt or slow
    input  wire logic [`EXP_W-1:0]  read_req_in,
    output logic      [`EXP_W-1:0]  read_ack_out,
    output logic      [`GPIO_W-1:0] pad_level_out,
    output logic      [7:0]         reads0_out,    // reads done on expander 0
    output logic      [7:0]         reads1_out     // reads done on expander 2
);
    logic [1:0] irq_line = 2'h0;                   // high while an expander pulls its line low
    logic [3:0] cnt [2]  = '{4'h0, 4'h0};          // cycles left before the read finishes
    logic [7:0] reads [2] = '{8'h00, 8'h00};
    logic [1:0] ack = 2'h0;                        // single driver of the acknowledge lines

    assign read_ack_out = ack;
    assign reads0_out = reads[0];
    assign reads1_out = reads[1];

    // wired pads: pull-ups win only where nobody drives or pulls low
    always_comb begin
        pad_level_out = 16'hFFFF & ~board_low_in;
        pad_level_out[`PIN_EXP0_IRQ] = ~irq_line[0];
        pad_level_out[`PIN_EXP2_IRQ] = ~irq_line[1];
        pad_level_out = (pad_oe_in & pad_val_in) | (~pad_oe_in & pad_level_out);
    end

    // read master: the ack rises ack_delay+1 cycles after the request, reading clears the expander line
    always @(posedge clk_in) begin
        for (int c = 0; c < 2; c++) begin
            if (irq_set_in[c]) begin
                irq_line[c] <= 1'b1;
            end
            if (ack[c]) begin
                ack[c] <= 1'b0;                    // one cycle only, request drops next edge
            end else if (read_req_in[c]) begin
                if (cnt[c] == 4'h0) begin
                    ack[c] <= 1'b1;
                    reads[c]        <= reads[c] + 8'h01;
                    if (!irq_stuck_in) begin
                        irq_line[c] <= 1'b0;
                    end
                end else begin
                    cnt[c] <= cnt[c] - 4'h1;
                end
            end else begin
                cnt[c] <= ack_delay_in;
            end
        end
    end
endmodule : hotplug_partner_model

// ===== include/gpio_mux_consts.svh
// constants for the general purpose pin multiplexer: widths, pin positions, masks, reset values
// assumes it is included by its bare name from the package and from the design modules
`ifndef GPIO_MUX_CONSTS_SVH
`define GPIO_MUX_CONSTS_SVH

`define GPIO_W              16          // number of general purpose pins
`define EXP_W               2           // expander interrupt channels (expander 0 and expander 2)

// pin positions of the alternate functions
`define PIN_PORT2_RST       0           // reset output for downstream port 2
`define PIN_PORT4_RST       1           // reset output for downstream port 4
`define PIN_EXP0_IRQ        2           // interrupt input from expander 0
`define PIN_EXP2_IRQ        4           // interrupt input from expander 2
`define PIN_EVENT           7           // general purpose event output
`define PIN_PORT6_RST       11          // reset output for downstream port 6

// channel index of each expander in the read request vector
`define EXP_CH0             0
`define EXP_CH2             1

// pins that own an alternate function at all; other select bits are forced to zero
`define ALT_MASK            16'h0897

// reset values
`define ALT_SEL_RST         16'h0000    // every pin starts as a plain pin
`define PIN_OUT_RST         16'h0000
`define PIN_OE_RST          16'h0000    // every pin starts as an input
`define SYNC_RST            16'hFFFF    // pins idle high behind pull-ups
`define EXP_RST             2'h0

`endif

// ===== include/gpio_mux_pkg.sv
// types shared by the pin multiplexer and its input synchroniser
// assumes the constants header sits on the include path
`include "gpio_mux_consts.svh"

package gpio_mux_pkg;

    // whole state of the multiplexer
    typedef struct packed {
        logic [`GPIO_W-1:0] alt_sel;    // alternate function selected, per pin
        logic [`GPIO_W-1:0] out_val;    // registered pin driver value
        logic [`GPIO_W-1:0] oe;         // registered pin output enable
        logic [`EXP_W-1:0]  irq_seen;   // expander interrupt seen asserted last cycle
        logic [`EXP_W-1:0]  read_req;   // pending expander read request
    } mux_state_t;

    // whole state of the three-stage synchroniser
    typedef struct packed {
        logic [`GPIO_W-1:0] s1;         // first stage, read only by the second
        logic [`GPIO_W-1:0] s2;
        logic [`GPIO_W-1:0] s3;
        logic [`GPIO_W-1:0] clean;      // accepted pin level
    } sync_state_t;

endpackage : gpio_mux_pkg

// ===== include/pin_sync_if.sv
// carrier between the multiplexer and its pin synchroniser
// assumes both ends run on the same system clock
`timescale 1ns/1ps
`include "gpio_mux_consts.svh"

interface pin_sync_if;
    logic [`GPIO_W-1:0] raw;            // pin levels straight from the pads
    logic               en;             // clock enable, freezes the synchroniser
    logic [`GPIO_W-1:0] clean;          // levels after agreement of stages two and three

    modport sync_side (input raw, input en, output clean);
    modport user_side (output raw, output en, input clean);
endinterface : pin_sync_if

// ===== logic/gpio_alternate_function_mux.sv
// general purpose pin multiplexer: plain software pins or fixed alternate functions
// assumes one system clock, a synchronous reset from fundamental reset, and pads outside
// that resolve the pin from gpio_out_out and gpio_oe_out
`timescale 1ns/1ps
`include "gpio_mux_consts.svh"

// Contract
// [R01] names ending in n are active low
// [R02] downstream ports are 2, 4, 6
// [R03] unselected pins behave as plain pins
// [R04] pin 0 alternate drives port 2 reset
// [R05] pin 1 alternate drives port 4 reset
// [R06] pin 2 alternate receives expander 0 interrupt
// [R07] pin 4 alternate receives expander 2 interrupt
// [R08] pin 7 alternate drives low event output
// [R09] each pin direction set independently by software
// [R10] selection written by software, management bus, or loader
// [R11] expander interrupt starts a hot-plug input read
// [R12] alternate outputs ignore software output value
module gpio_alternate_function_mux (
    input  wire logic                clk_in,
    input  wire logic                sys_rst_in,
    input  wire logic                clk_en_in,
    input  wire logic [`GPIO_W-1:0]  gpio_in_in,            // pad input levels
    output logic      [`GPIO_W-1:0]  gpio_out_out,          // pad driver values
    output logic      [`GPIO_W-1:0]  gpio_oe_out,           // pad output enables, high drives
    output logic      [`GPIO_W-1:0]  gpio_read_out,         // synchronised pin levels for software
    input  wire logic [`GPIO_W-1:0]  sw_dir_in,             // software direction, high is output
    input  wire logic [`GPIO_W-1:0]  sw_data_in,            // software output values
    input  wire logic                sw_alt_wr_in,          // software selection write strobe
    input  wire logic [`GPIO_W-1:0]  sw_alt_data_in,
    input  wire logic                smb_alt_wr_in,         // management bus selection write strobe
    input  wire logic [`GPIO_W-1:0]  smb_alt_data_in,
    input  wire logic                eeprom_alt_wr_in,      // configuration loader write strobe
    input  wire logic [`GPIO_W-1:0]  eeprom_alt_data_in,
    output logic      [`GPIO_W-1:0]  alt_sel_out,           // current selection
    input  wire logic                port2_reset_in,        // core wants port 2 in reset
    input  wire logic                port4_reset_in,        // core wants port 4 in reset
    input  wire logic                port6_reset_in,        // core wants port 6 in reset
    input  wire logic                system_event_in,       // core raises a general purpose event
    output logic      [`EXP_W-1:0]   expander_read_req_out, // read hot-plug inputs, held until ack
    input  wire logic [`EXP_W-1:0]   expander_read_ack_in   // management master took the request
);

    gpio_mux_pkg::mux_state_t st_reg;       // registered state
    gpio_mux_pkg::mux_state_t st_next;      // next state

    pin_sync_if sync_bus ();                // carrier to the synchroniser

    // alternate function levels, active low on the wire
    logic port2_reset_out_n;                // reset for downstream port 2
    logic port4_reset_out_n;                // reset for downstream port 4
    logic port6_reset_out_n;                // reset for downstream port 6
    logic system_event_out_n;               // event line toward the system
    logic expander0_irq_in_n;               // synchronised interrupt from expander 0
    logic expander2_irq_in_n;               // synchronised interrupt from expander 2
    logic [`EXP_W-1:0] irq_active;          // interrupt asserted and its function selected
    logic [`EXP_W-1:0] irq_edge;            // new assertion this cycle

    // pick the alternate value when selected, else the software value
    function automatic logic pick_drive(input logic alt, input logic fn_val, input logic sw_val);
        pick_drive = alt ? fn_val : sw_val;
    endfunction : pick_drive

    // a request is set by an edge and held until acknowledged; the set wins over the ack
    function automatic logic hold_req(input logic set, input logic held, input logic ack);
        hold_req = set | (held & ~ack);
    endfunction : hold_req

    // pins pass four flops before anything here looks at them
    assign sync_bus.raw = gpio_in_in;
    assign sync_bus.en  = clk_en_in;

    pin_sync u_pin_sync (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .sync_bus   (sync_bus)
    );

    // active-low levels: asserted request gives a low wire
    assign port2_reset_out_n  = ~port2_reset_in;                     // [R01] [R02]
    assign port4_reset_out_n  = ~port4_reset_in;                     // [R01] [R02]
    assign port6_reset_out_n  = ~port6_reset_in;                     // [R01] [R02]
    assign system_event_out_n = ~system_event_in;                    // [R01]
    assign expander0_irq_in_n = sync_bus.clean[`PIN_EXP0_IRQ];       // [R06]
    assign expander2_irq_in_n = sync_bus.clean[`PIN_EXP2_IRQ];       // [R07]

    // an interrupt only counts while its pin has the interrupt function selected
    assign irq_active[`EXP_CH0] = st_reg.alt_sel[`PIN_EXP0_IRQ] & ~expander0_irq_in_n;   // [R01] [R06]
    assign irq_active[`EXP_CH2] = st_reg.alt_sel[`PIN_EXP2_IRQ] & ~expander2_irq_in_n;   // [R01] [R07]
    assign irq_edge             = irq_active & ~st_reg.irq_seen;

    // next state: selection writes, pin drivers, expander read requests
    always_comb begin
        st_next = st_reg;

        // selection writers; software first, then management bus, then loader
        if (sw_alt_wr_in) begin
            st_next.alt_sel = sw_alt_data_in & `ALT_MASK;            // [R10]
        end else if (smb_alt_wr_in) begin
            st_next.alt_sel = smb_alt_data_in & `ALT_MASK;           // [R10]
        end else if (eeprom_alt_wr_in) begin
            st_next.alt_sel = eeprom_alt_data_in & `ALT_MASK;        // [R10]
        end

        // plain pins: software value and per-pin direction
        st_next.out_val = sw_data_in;                                // [R03]
        st_next.oe      = sw_dir_in;                                 // [R09]

        // alternate outputs override both value and direction
        st_next.out_val[`PIN_PORT2_RST] = pick_drive(st_reg.alt_sel[`PIN_PORT2_RST],
                                                     port2_reset_out_n, sw_data_in[`PIN_PORT2_RST]);  // [R04] [R12]
        st_next.out_val[`PIN_PORT4_RST] = pick_drive(st_reg.alt_sel[`PIN_PORT4_RST],
                                                     port4_reset_out_n, sw_data_in[`PIN_PORT4_RST]);  // [R05] [R12]
        st_next.out_val[`PIN_PORT6_RST] = pick_drive(st_reg.alt_sel[`PIN_PORT6_RST],
                                                     port6_reset_out_n, sw_data_in[`PIN_PORT6_RST]);  // [R02] [R12]
        st_next.out_val[`PIN_EVENT]     = pick_drive(st_reg.alt_sel[`PIN_EVENT],
                                                     system_event_out_n, sw_data_in[`PIN_EVENT]);     // [R08] [R12]
        st_next.oe[`PIN_PORT2_RST] = st_reg.alt_sel[`PIN_PORT2_RST] | sw_dir_in[`PIN_PORT2_RST];      // [R04]
        st_next.oe[`PIN_PORT4_RST] = st_reg.alt_sel[`PIN_PORT4_RST] | sw_dir_in[`PIN_PORT4_RST];      // [R05]
        st_next.oe[`PIN_PORT6_RST] = st_reg.alt_sel[`PIN_PORT6_RST] | sw_dir_in[`PIN_PORT6_RST];      // [R02]
        st_next.oe[`PIN_EVENT]     = st_reg.alt_sel[`PIN_EVENT] | sw_dir_in[`PIN_EVENT];              // [R08]

        // alternate inputs release the pad so the expander can pull it
        st_next.oe[`PIN_EXP0_IRQ] = ~st_reg.alt_sel[`PIN_EXP0_IRQ] & sw_dir_in[`PIN_EXP0_IRQ];        // [R06]
        st_next.oe[`PIN_EXP2_IRQ] = ~st_reg.alt_sel[`PIN_EXP2_IRQ] & sw_dir_in[`PIN_EXP2_IRQ];        // [R07]

        // edge triggered so one held-low interrupt yields one read, not a stream
        st_next.irq_seen = irq_active;
        for (int i = 0; i < `EXP_W; i++) begin
            st_next.read_req[i] = hold_req(irq_edge[i], st_reg.read_req[i], expander_read_ack_in[i]); // [R11]
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_reg <= '{alt_sel: `ALT_SEL_RST, out_val: `PIN_OUT_RST, oe: `PIN_OE_RST,
                        irq_seen: `EXP_RST, read_req: `EXP_RST};
        end else if (clk_en_in) begin
            st_reg <= st_next;
        end
    end

    // every data output comes straight from a flop
    assign gpio_out_out          = st_reg.out_val;
    assign gpio_oe_out           = st_reg.oe;
    assign gpio_read_out         = sync_bus.clean;
    assign alt_sel_out           = st_reg.alt_sel;
    assign expander_read_req_out = st_reg.read_req;

    // checks of the pin behaviour
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    property p_port6_reset;
        clk_en_in && st_reg.alt_sel[`PIN_PORT6_RST]
            |=> gpio_oe_out[`PIN_PORT6_RST] && (gpio_out_out[`PIN_PORT6_RST] == !$past(port6_reset_in));
    endproperty
    a_port6_reset: assert property (p_port6_reset) else $error("port 6 reset pin wrong"); // [R02]

    property p_plain_pin;
        clk_en_in && !st_reg.alt_sel[`PIN_PORT2_RST]
            |=> gpio_out_out[`PIN_PORT2_RST] == $past(sw_data_in[`PIN_PORT2_RST]);
    endproperty
    a_plain_pin: assert property (p_plain_pin) else $error("plain pin lost software value"); // [R03]

    property p_port2_reset;
        clk_en_in && st_reg.alt_sel[`PIN_PORT2_RST] && port2_reset_in
            |=> gpio_oe_out[`PIN_PORT2_RST] && !gpio_out_out[`PIN_PORT2_RST];
    endproperty
    a_port2_reset: assert property (p_port2_reset) else $error("port 2 reset not driven low"); // [R04]

    property p_port4_reset;
        clk_en_in && st_reg.alt_sel[`PIN_PORT4_RST]
            |=> gpio_oe_out[`PIN_PORT4_RST] && (gpio_out_out[`PIN_PORT4_RST] == !$past(port4_reset_in));
    endproperty
    a_port4_reset: assert property (p_port4_reset) else $error("port 4 reset pin wrong"); // [R05]

    property p_exp0_input;
        clk_en_in && st_reg.alt_sel[`PIN_EXP0_IRQ] |=> !gpio_oe_out[`PIN_EXP0_IRQ];
    endproperty
    a_exp0_input: assert property (p_exp0_input) else $error("expander 0 pin still driven"); // [R06]

    property p_exp2_input;
        clk_en_in && st_reg.alt_sel[`PIN_EXP2_IRQ] |=> !gpio_oe_out[`PIN_EXP2_IRQ];
    endproperty
    a_exp2_input: assert property (p_exp2_input) else $error("expander 2 pin still driven"); // [R07]

    property p_event_out;
        clk_en_in && st_reg.alt_sel[`PIN_EVENT]
            |=> gpio_oe_out[`PIN_EVENT] && (gpio_out_out[`PIN_EVENT] != $past(system_event_in));
    endproperty
    a_event_out: assert property (p_event_out) else $error("event pin not inverted event"); // [R08]

    property p_direction;
        clk_en_in && !st_reg.alt_sel[`PIN_EXP0_IRQ] |=> gpio_oe_out[`PIN_EXP0_IRQ] == $past(sw_dir_in[`PIN_EXP0_IRQ]);
    endproperty
    a_direction: assert property (p_direction) else $error("pin direction not software's"); // [R09]

    property p_alt_write;
        clk_en_in && sw_alt_wr_in |=> alt_sel_out == ($past(sw_alt_data_in) & `ALT_MASK);
    endproperty
    a_alt_write: assert property (p_alt_write) else $error("selection write not taken"); // [R10]

    property p_irq_read;
        clk_en_in && irq_edge[`EXP_CH0] |=> expander_read_req_out[`EXP_CH0];
    endproperty
    a_irq_read: assert property (p_irq_read) else $error("expander 0 read not requested"); // [R11]

    property p_irq_read2;
        clk_en_in && irq_edge[`EXP_CH2] |=> expander_read_req_out[`EXP_CH2];
    endproperty
    a_irq_read2: assert property (p_irq_read2) else $error("expander 2 read not requested"); // [R11]

    // an expander 0 request must not vanish before the management master has taken it
    property p_req_hold;
        clk_en_in && expander_read_req_out[`EXP_CH0] && !expander_read_ack_in[`EXP_CH0]
            |=> expander_read_req_out[`EXP_CH0];
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("expander 0 request dropped before ack"); // [R11]

    property p_ignore_sw;
        clk_en_in && st_reg.alt_sel[`PIN_PORT4_RST] && !port4_reset_in && !sw_data_in[`PIN_PORT4_RST]
            |=> gpio_out_out[`PIN_PORT4_RST];
    endproperty
    a_ignore_sw: assert property (p_ignore_sw) else $error("software value leaked to port 4 reset"); // [R12]

endmodule : gpio_alternate_function_mux

// ===== logic/pin_sync.sv
// three-stage synchroniser for the general purpose pin inputs
// assumes pins are asynchronous to clk_in; a change is accepted once stages two and three agree
`timescale 1ns/1ps
`include "gpio_mux_consts.svh"

module pin_sync (
    input  wire logic     clk_in,
    input  wire logic     sys_rst_in,
    pin_sync_if.sync_side sync_bus
);

    gpio_mux_pkg::sync_state_t st_reg;      // registered state
    gpio_mux_pkg::sync_state_t st_next;     // next state

    // next state: shift the stages, accept a bit only where stages two and three agree
    always_comb begin
        st_next       = st_reg;
        st_next.s1    = sync_bus.raw;
        st_next.s2    = st_reg.s1;
        st_next.s3    = st_reg.s2;
        // the first stage is deliberately not looked at here, it may still be metastable
        st_next.clean = (st_reg.s2 & st_reg.s3) | (st_reg.clean & (st_reg.s2 ^ st_reg.s3));
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_reg <= '{s1: `SYNC_RST, s2: `SYNC_RST, s3: `SYNC_RST, clean: `SYNC_RST};
        end else if (sync_bus.en) begin
            st_reg <= st_next;
        end
    end

    assign sync_bus.clean = st_reg.clean;

endmodule : pin_sync
